// ---- hdl/pmc_consts.svh ----
// constants for the parallel master port control block
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_ADDR_W         4
`define PMC_CTRL_ADDR      4'h0
`define PMC_ADDR_ADDR      4'h1
`define PMC_DATA_ADDR      4'h2
`define PMC_STAT_ADDR      4'h3
`define PMC_CTRL_RESET     16'h0000
`define PMC_CTRL_WMASK     16'hBFEF
`define PMC_BIT_EN         15
`define PMC_BIT_SIDL       13
`define PMC_MUX_HI         12
`define PMC_MUX_LO         11
`define PMC_BIT_BEEN       10
`define PMC_BIT_WREN       9
`define PMC_BIT_RDEN       8
`define PMC_CSF_HI         7
`define PMC_CSF_LO         6
`define PMC_BIT_ALP        5
`define PMC_BIT_SELECT_ONE_POLARITY       3
`define PMC_CSF_CHIPSEL    2'h2
`define PMC_STROBE_NS      8
`define PMC_CLK_NS         4
`define PMC_STROBE_CYC     ((`PMC_STROBE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`endif

// ---- hdl/pmc_pkg.sv ----
// types for the parallel master port control block
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_MUX_SEPARATE,
    PMC_MUX_LOW8,
    PMC_MUX_ALL16,
    PMC_MUX_RESERVED
  } pmc_mux_t;
  typedef enum logic [2:0] {
    PMC_IDLE,
    PMC_ALO,
    PMC_AHI,
    PMC_STROBE,
    PMC_DONE
  } pmc_state_t;
endpackage

// ---- hdl/pmc_strobe_timer.sv ----
// counts out the width of one strobe phase
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_strobe_timer #(
  parameter int unsigned CYCLES = `PMC_STROBE_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_start,
  input  wire logic i_hold,
  output logic      o_done
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       run;
    logic       done;
  } pmc_tmr_t;
  pmc_tmr_t st_ff;
  pmc_tmr_t nxt_st;

  // hold freezes the count so an idle stop resumes mid phase
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (i_start) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = 8'h00;
    end else if (st_ff.run && !i_hold) begin
      if (st_ff.cnt == 8'(CYCLES - 1)) begin
        nxt_st.run  = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_done = st_ff.done;
endmodule
`default_nettype wire

// ---- hdl/pmc_parallel_master_port_control.sv ----
// control register and pin sequencing of the parallel master port
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_parallel_master_port_control
  import pmc_pkg::*;
(
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_n,
  input  wire logic [`PMC_ADDR_W-1:0] i_reg_addr,
  input  wire logic [15:0]            i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic      [15:0]            o_reg_rdata,
  input  wire logic                   i_idle_mode,
  input  wire logic [7:0]             i_port_data_lines,
  output logic      [7:0]             o_port_data_lines,
  output logic                        o_port_data_lines_oe,
  output logic      [15:0]            o_port_address_lines,
  output logic                        o_byte_enable_pin,
  output logic                        o_byte_enable_pin_oe,
  output logic                        o_write_strobe_pin,
  output logic                        o_write_strobe_pin_oe,
  output logic                        o_read_strobe_pin,
  output logic                        o_read_strobe_pin_oe,
  output logic                        o_chip_select_one_pin,
  output logic                        o_chip_select_one_pin_oe,
  output logic                        o_low_address_latch_pin,
  output logic                        o_high_address_latch_pin
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        dir_rd;
    logic        busy;
    logic        idle_s1;
    logic        idle_s2;
    logic [7:0]  din_s1;
    logic [7:0]  din_s2;
    pmc_state_t  state;
    logic        timer_go;
    logic [15:0] rd_out;
    logic [7:0]  pd_out;
    logic        pd_oe;
    logic [15:0] pa_out;
    logic        alo;
    logic        ahi;
    logic        strobe;
  } pmc_state_s_t;

  pmc_state_s_t st_ff;
  pmc_state_s_t nxt_st;
  logic         phase_done;
  logic         halted;
  logic         port_on;
  pmc_mux_t     mux_mode;
  logic         cs_is_chipsel;
  logic         cs_active;
  logic         alo_live;
  logic         ahi_live;

  // control fields decoded from the register
  assign port_on       = st_ff.ctrl[`PMC_BIT_EN];
  assign mux_mode      = pmc_mux_t'(st_ff.ctrl[`PMC_MUX_HI:`PMC_MUX_LO]);
  assign cs_is_chipsel = (st_ff.ctrl[`PMC_CSF_HI:`PMC_CSF_LO] == `PMC_CSF_CHIPSEL);
  // stop in idle only when software asked for it
  assign halted        = st_ff.ctrl[`PMC_BIT_SIDL] && st_ff.idle_s2;

  pmc_strobe_timer #(
    .CYCLES (`PMC_STROBE_CYC)
  ) u_timer (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_start (st_ff.timer_go),
    .i_hold  (halted),
    .o_done  (phase_done)
  );

  // register access, synchronisers and the access sequencer
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.timer_go = 1'b0;
    nxt_st.rd_out   = 16'h0000;
    nxt_st.idle_s1  = i_idle_mode;
    nxt_st.idle_s2  = st_ff.idle_s1;
    nxt_st.din_s1   = i_port_data_lines;
    nxt_st.din_s2   = st_ff.din_s1;
    // reserved bits are masked so they stay zero
    if (i_reg_wr) begin
      case (i_reg_addr)
        `PMC_CTRL_ADDR: nxt_st.ctrl = i_reg_wdata & `PMC_CTRL_WMASK;
        `PMC_ADDR_ADDR: nxt_st.addr = i_reg_wdata;
        `PMC_DATA_ADDR: begin
          // a start while disabled or busy is dropped, data and direction too,
          // so a running access never sees its byte or direction change
          if (port_on && !st_ff.busy) begin
            nxt_st.busy   = 1'b1;
            nxt_st.wdata  = i_reg_wdata[7:0];
            nxt_st.dir_rd = i_reg_wdata[15];
          end
        end
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `PMC_CTRL_ADDR: nxt_st.rd_out = st_ff.ctrl & `PMC_CTRL_WMASK;
        `PMC_ADDR_ADDR: nxt_st.rd_out = st_ff.addr;
        `PMC_DATA_ADDR: nxt_st.rd_out = {8'h00, st_ff.rdata};
        `PMC_STAT_ADDR: nxt_st.rd_out = {15'h0000, st_ff.busy};
        default:        nxt_st.rd_out = 16'h0000;
      endcase
    end
    // sequencer; held in place while halted unless the port is disabled, which returns it to idle
    if (!port_on) begin
      nxt_st.state  = PMC_IDLE;
      nxt_st.busy   = 1'b0;
      nxt_st.alo    = 1'b0;
      nxt_st.ahi    = 1'b0;
      nxt_st.strobe = 1'b0;
      nxt_st.pd_oe  = 1'b0;
    end else if (!halted) begin
      case (st_ff.state)
        PMC_IDLE: begin
          if (st_ff.busy) begin
            nxt_st.timer_go = 1'b1;
            nxt_st.pa_out   = st_ff.addr;
            case (mux_mode)
              PMC_MUX_ALL16, PMC_MUX_LOW8: begin
                nxt_st.state = PMC_ALO;
                nxt_st.alo   = 1'b1;
                nxt_st.pd_out = st_ff.addr[7:0];
                nxt_st.pd_oe  = 1'b1;
              end
              default: begin
                nxt_st.state  = PMC_STROBE;
                nxt_st.strobe = 1'b1;
                nxt_st.pd_out = st_ff.wdata;
                nxt_st.pd_oe  = !st_ff.dir_rd;
              end
            endcase
          end
        end
        PMC_ALO: begin
          if (phase_done) begin
            nxt_st.alo      = 1'b0;
            nxt_st.timer_go = 1'b1;
            if (mux_mode == PMC_MUX_ALL16) begin
              nxt_st.state  = PMC_AHI;
              nxt_st.ahi    = 1'b1;
              nxt_st.pd_out = st_ff.addr[15:8];
            end else begin
              nxt_st.state  = PMC_STROBE;
              nxt_st.strobe = 1'b1;
              nxt_st.pd_out = st_ff.wdata;
              nxt_st.pd_oe  = !st_ff.dir_rd;
            end
          end
        end
        PMC_AHI: begin
          if (phase_done) begin
            nxt_st.ahi      = 1'b0;
            nxt_st.timer_go = 1'b1;
            nxt_st.state    = PMC_STROBE;
            nxt_st.strobe   = 1'b1;
            nxt_st.pd_out   = st_ff.wdata;
            nxt_st.pd_oe    = !st_ff.dir_rd;
          end
        end
        PMC_STROBE: begin
          if (phase_done) begin
            nxt_st.strobe = 1'b0;
            nxt_st.state  = PMC_DONE;
            if (st_ff.dir_rd) begin
              nxt_st.rdata = st_ff.din_s2;
            end
          end
        end
        PMC_DONE: begin
          nxt_st.pd_oe = 1'b0;
          nxt_st.busy  = 1'b0;
          nxt_st.state = PMC_IDLE;
        end
        default: nxt_st.state = PMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff       <= '0;
      st_ff.ctrl  <= `PMC_CTRL_RESET;
      st_ff.state <= PMC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // address lines: dedicated upper bits depend on mux mode
  always_comb begin
    case (mux_mode)
      PMC_MUX_ALL16: o_port_address_lines = 16'h0000;
      PMC_MUX_LOW8:  o_port_address_lines = {5'h00, st_ff.pa_out[10:8], 8'h00};
      default:       o_port_address_lines = st_ff.pa_out;
    endcase
  end

  // strobe pins only when their enable bit is set
  // gated by the enable so a disable silences the pins at once, not a cycle late
  assign cs_active = port_on && st_ff.busy && st_ff.state != PMC_IDLE;
  assign alo_live  = port_on && st_ff.alo;
  assign ahi_live  = port_on && st_ff.ahi;
  assign o_reg_rdata           = st_ff.rd_out;
  assign o_port_data_lines     = st_ff.pd_out;
  assign o_port_data_lines_oe  = port_on && st_ff.pd_oe;
  assign o_byte_enable_pin     = port_on && st_ff.strobe;
  assign o_byte_enable_pin_oe  = port_on && st_ff.ctrl[`PMC_BIT_BEEN];
  assign o_write_strobe_pin    = port_on && st_ff.strobe && !st_ff.dir_rd;
  assign o_write_strobe_pin_oe = port_on && st_ff.ctrl[`PMC_BIT_WREN];
  assign o_read_strobe_pin     = port_on && st_ff.strobe && st_ff.dir_rd;
  assign o_read_strobe_pin_oe  = port_on && st_ff.ctrl[`PMC_BIT_RDEN];
  // polarity only applies when the pin is a strobe, not address
  assign o_chip_select_one_pin    = cs_is_chipsel ?
                                    (cs_active ~^ st_ff.ctrl[`PMC_BIT_SELECT_ONE_POLARITY]) :
                                    st_ff.pa_out[14];
  assign o_chip_select_one_pin_oe = port_on;
  assign o_low_address_latch_pin  = (mux_mode == PMC_MUX_SEPARATE) ? st_ff.pa_out[0] :
                                    (alo_live ~^ st_ff.ctrl[`PMC_BIT_ALP]);
  assign o_high_address_latch_pin = (mux_mode == PMC_MUX_SEPARATE) ? st_ff.pa_out[1] :
                                    (ahi_live ~^ st_ff.ctrl[`PMC_BIT_ALP]);
endmodule
`default_nettype wire

// ---- testbench/pmc_properties.sv ----
// checker for the parallel master port control block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_control_checker (
  input wire logic                   i_clock,
  input wire logic                   i_rst_n,
  input wire logic [`PMC_ADDR_W-1:0] i_reg_addr,
  input wire logic [15:0]            i_reg_wdata,
  input wire logic                   i_reg_wr,
  input wire logic                   i_reg_rd,
  input wire logic [15:0]            o_reg_rdata,
  input wire logic [15:0]            o_port_address_lines,
  input wire logic                   o_port_data_lines_oe,
  input wire logic                   o_byte_enable_pin,
  input wire logic                   o_read_strobe_pin,
  input wire logic                   o_byte_enable_pin_oe,
  input wire logic                   o_write_strobe_pin,
  input wire logic                   o_write_strobe_pin_oe,
  input wire logic                   o_read_strobe_pin_oe,
  input wire logic                   o_chip_select_one_pin,
  input wire logic                   o_chip_select_one_pin_oe,
  input wire logic                   o_low_address_latch_pin,
  input wire logic                   o_high_address_latch_pin
);
  logic [15:0] ctl_ff;
  logic [15:0] adr_ff;
  // shadow of control and address; masked so reserved bits stay zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_ff <= 16'h0000;
      adr_ff <= 16'h0000;
    end else if (i_reg_wr && i_reg_addr == `PMC_CTRL_ADDR) begin
      ctl_ff <= i_reg_wdata & 16'hBFEF;
    end else if (i_reg_wr && i_reg_addr == `PMC_ADDR_ADDR) begin
      adr_ff <= i_reg_wdata;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_OFF_NO_DRIVE:
    assert property (!ctl_ff[15] |-> !(o_write_strobe_pin | o_write_strobe_pin_oe
      | o_read_strobe_pin | o_byte_enable_pin | o_port_data_lines_oe
      | o_read_strobe_pin_oe | o_chip_select_one_pin_oe)) else $error("pins driven while off");
  AST_CTRL_READBACK:
    assert property (i_reg_rd && i_reg_addr == `PMC_CTRL_ADDR |=> o_reg_rdata == $past(ctl_ff))
      else $error("control readback wrong");
  AST_PIN_OE:
    assert property ({o_byte_enable_pin_oe, o_write_strobe_pin_oe, o_read_strobe_pin_oe}
      == ({3{ctl_ff[15]}} & ctl_ff[10:8])) else $error("pin enable wrong");
  AST_MUX_ALL16:
    assert property (ctl_ff[12:11] == 2'b10 |-> o_port_address_lines == 16'h0000)
      else $error("address lines busy in full mux");
  AST_MUX_LOW8:
    assert property (ctl_ff[12:11] == 2'b01 && (o_write_strobe_pin || o_read_strobe_pin) |->
      o_port_address_lines == {5'h00, adr_ff[10:8], 8'h00}) else $error("upper address wrong");
  // address pins hold the address of the running access, so look during its strobe
  AST_MUX_SEPARATE:
    assert property (ctl_ff[12:11] == 2'b00 && (o_write_strobe_pin || o_read_strobe_pin)
      |-> o_port_address_lines == adr_ff
      && o_low_address_latch_pin == adr_ff[0] && o_high_address_latch_pin == adr_ff[1])
      else $error("separate address wrong");
  AST_CS_ACTIVE:
    assert property (ctl_ff[7:6] == 2'b10 && o_write_strobe_pin |->
      o_chip_select_one_pin == ctl_ff[3]) else $error("chip select level wrong");
  AST_LATCH_IDLE:
    assert property ((ctl_ff[12] ^ ctl_ff[11]) && !ctl_ff[15] |-> o_low_address_latch_pin
      == !ctl_ff[5] && o_high_address_latch_pin == !ctl_ff[5]) else $error("latch idle wrong");
endmodule
bind pmc_parallel_master_port_control pmc_control_checker u_chk (.*);
`default_nettype wire

// ---- testbench/pmc_peripheral_model.sv ----
// byte-wide peripheral memory on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module pmc_peripheral_model (
  input  wire logic       i_clock,
  input  wire logic       i_sep,
  input  wire logic       i_alp,
  input  wire logic       i_latch,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_drv,
  input  wire logic [7:0] i_data,
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_data
);
  logic [7:0] mem [256];
  logic [7:0] lat_ff = 8'h00;
  logic [7:0] junk_ff = 8'h5A;
  logic [1:0] hold_ff = 2'h0;
  wire  [7:0] ix = i_sep ? i_addr : lat_ff;
  // read data held briefly after the strobe, then the released bus wanders
  assign o_data = (i_rd || hold_ff != 2'h0) ? mem[ix] : junk_ff;
  always @(posedge i_clock) begin
    if (!i_sep && i_drv && i_latch == i_alp) lat_ff <= i_data;
    if (i_wr && i_drv) mem[ix] <= i_data;
    hold_ff <= i_rd ? 2'h3 : hold_ff - {1'b0, hold_ff != 2'h0};
    junk_ff <= ~junk_ff;
  end
endmodule
`default_nettype wire

// ---- testbench/parallel_master_port_control_test.sv ----
// directed register and access tests for the parallel master port control
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module parallel_master_port_control_test;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0, rd = 1'b0, idle = 1'b0, sep = 1'b1, latch_strobe_polarity = 1'b0;
  logic [15:0] rdata, v, pa;
  logic [7:0]  pd_out, pd_in;
  logic        pd_oe, be_oe, wr_pin, wr_oe, rd_pin, rd_oe, lat_lo;
  int          num_errors = 0;
  int          compares = 0;
  pmc_parallel_master_port_control DUT (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_idle_mode(idle),
    .i_port_data_lines(pd_in), .o_port_data_lines(pd_out), .o_port_data_lines_oe(pd_oe),
    .o_port_address_lines(pa), .o_byte_enable_pin(), .o_byte_enable_pin_oe(be_oe),
    .o_write_strobe_pin(wr_pin), .o_write_strobe_pin_oe(wr_oe), .o_read_strobe_pin(rd_pin),
    .o_read_strobe_pin_oe(rd_oe), .o_chip_select_one_pin(), .o_chip_select_one_pin_oe(),
    .o_low_address_latch_pin(lat_lo), .o_high_address_latch_pin());
  pmc_peripheral_model u_periph (
    .i_clock(i_clock), .i_sep(sep), .i_alp(latch_strobe_polarity), .i_latch(lat_lo), .i_wr(wr_pin),
    .i_rd(rd_pin), .i_drv(pd_oe), .i_data(pd_out), .i_addr(pa[7:0]), .o_data(pd_in));
  initial forever #2 i_clock = ~i_clock;
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded poll of the busy flag
  task automatic wait_idle;
    for (int n = 0; n < 40; n++) begin
      rd_reg(`PMC_STAT_ADDR, v);
      if (v[0] === 1'b0) break;
    end
    chk(v, 16'h0000);
  endtask
  task results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    num_errors++;
    results;
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd_reg(`PMC_CTRL_ADDR, v);
    chk(v, 16'h0000);
    wr_reg(4'hA, 16'hFFFF);
    rd_reg(4'hA, v);
    chk(v, 16'h0000);
    wr_reg(`PMC_CTRL_ADDR, 16'hE7BF);
    rd_reg(`PMC_CTRL_ADDR, v);
    chk(v, 16'hA7AF);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`PMC_CTRL_ADDR, 16'h8700 ^ (16'h0100 << i));
      #1 chk({13'h0, be_oe, wr_oe, rd_oe}, 16'h0007 ^ (16'h0001 << i));
    end
    wr_reg(`PMC_CTRL_ADDR, 16'h0700);
    #1 chk({13'h0, be_oe, wr_oe, rd_oe}, 16'h0000);
    $display("test registers done");
    idle <= 1'b1;
    // idle-stop clear, so accesses run on; the reserved mux code is skipped
    for (int m = 0; m < 3; m++) begin
      sep <= (m == 0);
      latch_strobe_polarity <= m[0];
      v = {3'b000, 2'(m), 3'h7, 2'h2, m[0], 1'b0, m[1], 3'h0};
      wr_reg(`PMC_CTRL_ADDR, v);
      wr_reg(`PMC_CTRL_ADDR, v | 16'h8000);
      wr_reg(`PMC_ADDR_ADDR, {8'h05, 5'h00, 3'(m)});
      wr_reg(`PMC_DATA_ADDR, {8'h00, 8'hA0 + 8'(m)});
      wait_idle;
      wr_reg(`PMC_DATA_ADDR, 16'h8000);
      wait_idle;
      rd_reg(`PMC_DATA_ADDR, v);
      chk({8'h00, v[7:0]}, {8'h00, 8'hA0 + 8'(m)});
    end
    $display("test accesses done");
    idle <= 1'b0;
    sep <= 1'b0;
    wr_reg(`PMC_CTRL_ADDR, 16'h3780);
    wr_reg(`PMC_CTRL_ADDR, 16'hB780);
    wr_reg(`PMC_DATA_ADDR, 16'h0055);
    idle <= 1'b1;
    repeat (20) @(posedge i_clock);
    rd_reg(`PMC_STAT_ADDR, v);
    chk(v, 16'h0001);
    wr_reg(`PMC_DATA_ADDR, 16'h0077);
    idle <= 1'b0;
    wait_idle;
    wr_reg(`PMC_DATA_ADDR, 16'h8000);
    wait_idle;
    rd_reg(`PMC_DATA_ADDR, v);
    chk(v, 16'h0055);
    wr_reg(`PMC_DATA_ADDR, 16'h0066);
    idle <= 1'b1;
    repeat (8) @(posedge i_clock);
    wr_reg(`PMC_CTRL_ADDR, 16'h3780);
    idle <= 1'b0;
    rd_reg(`PMC_STAT_ADDR, v);
    chk(v, 16'h0000);
    $display("test idle stop and abort done");
    results;
  end
endmodule
`default_nettype wire
